// [ccpm_params.svh]
// Purpose: constants for the clock speed and power mode controller
// Assumes: one aclk cycle stands for one oscillator period
// Notes: register offsets are word indexes; byte address is index times four
`ifndef CCPM_PARAMS_SVH
`define CCPM_PARAMS_SVH

`define CCPM_ADDR_W 12
`define CCPM_IDX_POWER_CONTROL_REG 12'h087
`define CCPM_IDX_CLOCK_RATE_SELECT 12'h08F
`define CCPM_IDX_STAT 12'h090

`define CCPM_CLOCK_RATE_SELECT_RST 8'h00
`define CCPM_POWER_CONTROL_REG_RST 8'h10
`define CCPM_POWER_CONTROL_REG_IDLE 0
`define CCPM_POWER_CONTROL_REG_PD 1
`define CCPM_POWER_CONTROL_REG_POF 4
`define CCPM_POWER_CONTROL_REG_RSVD 5
`define CCPM_CK_X2 0

`define CCPM_STD_PERIODS 12
`define CCPM_X2_PERIODS 6
`define CCPM_WARM_RST_PERIODS 24
`define CCPM_CYC_PER_PERIOD 1
`define CCPM_WARM_RST_CYC (`CCPM_WARM_RST_PERIODS * `CCPM_CYC_PER_PERIOD)

`define CCPM_RESP_OKAY 2'h0
`define CCPM_RESP_SLVERR 2'h2

`endif

// [ccpm_pkg.sv]
// Purpose: types and shared decode for the clock speed and power mode controller
// Assumes: constants come from ccpm_params.svh
// Notes: peripheral struct order follows the clock select bits 7 down to 1
`include "ccpm_params.svh"

package ccpm_pkg;

  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_PDOWN, PM_PDWAKE} ccpm_mode_e;

  typedef enum logic [1:0] {REG_NONE, REG_POWER_CONTROL_REG, REG_CLOCK_RATE_SELECT, REG_STAT} ccpm_reg_e;

  typedef struct packed {
    logic can;
    logic wdt;
    logic programmable_counter_array;
    logic uart;
    logic t2;
    logic t1;
    logic t0;
  } ccpm_periph_s;

  // cycle tick at end of a 12-period frame, also at mid frame when fast
  function automatic logic ccpm_tick(input logic [3:0] cnt, input logic fast);
    ccpm_tick = (cnt == 4'(`CCPM_STD_PERIODS - 1)) ||
                (fast && cnt == 4'(`CCPM_X2_PERIODS - 1));
  endfunction

endpackage

// [ccpm_top.sv]
// Purpose: machine cycle enables, speed select and idle/power-down control
// Assumes: aclk is the crystal oscillator; registers reached over AXI4-Lite
// Notes: outputs lag the internal mode by one cycle
`timescale 1ns/1ps
`include "ccpm_params.svh"

module ccpm_top
  import ccpm_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [`CCPM_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [`CCPM_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // device pins
  input wire logic reset_pin,
  input wire logic ext_irq_zero_n,
  input wire logic ext_irq_one_n,
  // core side
  input wire logic irq_pending,
  input wire logic adc_idle_mode,
  input wire logic adc_conv_done,
  input wire logic int_warm_rst_req,
  // clock enables and status
  output logic cpu_cycle_en,
  output ccpm_periph_s periph_cycle_en,
  output logic osc_enable,
  output logic core_reset,
  output logic ram_access_block,
  output logic cpu_clock_halted
);

  function automatic ccpm_reg_e reg_sel(input logic [`CCPM_ADDR_W-1:0] a);
    if (a == (`CCPM_IDX_POWER_CONTROL_REG << 2)) reg_sel = REG_POWER_CONTROL_REG;
    else if (a == (`CCPM_IDX_CLOCK_RATE_SELECT << 2)) reg_sel = REG_CLOCK_RATE_SELECT;
    else if (a == (`CCPM_IDX_STAT << 2)) reg_sel = REG_STAT;
    else reg_sel = REG_NONE;
  endfunction

  logic rp_s1_ff, rp_s2_ff, i0_s1_ff, i0_s2_ff, i1_s1_ff, i1_s2_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_have_ff, w_have_ff;
  logic [`CCPM_ADDR_W-1:0] aw_addr_ff;
  logic [7:0] w_data_ff;
  logic w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [7:0] clock_rate_select_ff, power_control_reg_misc_ff;
  ccpm_mode_e mode_ff;
  logic adc_idle_ff, half_ff, x2_eff_ff;
  logic [3:0] cnt_ff;
  logic [4:0] rst_cnt_ff, irst_cnt_ff;
  logic core_rst_ff, ram_block_ff;
  logic cpu_en_ff, osc_en_ff, halted_ff;
  ccpm_periph_s periph_en_ff;
  logic wr_go, power_control_reg_wr, pin_wake;
  ccpm_reg_e wsel, rsel;

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign cpu_cycle_en = cpu_en_ff;
  assign periph_cycle_en = periph_en_ff;
  assign osc_enable = osc_en_ff;
  assign core_reset = core_rst_ff;
  assign ram_access_block = ram_block_ff;
  assign cpu_clock_halted = halted_ff;

  // pins from outside pass two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rp_s1_ff <= 1'b0;
      rp_s2_ff <= 1'b0;
      i0_s1_ff <= 1'b1;
      i0_s2_ff <= 1'b1;
      i1_s1_ff <= 1'b1;
      i1_s2_ff <= 1'b1;
    end else begin
      rp_s1_ff <= reset_pin;
      rp_s2_ff <= rp_s1_ff;
      i0_s1_ff <= ext_irq_zero_n;
      i0_s2_ff <= i0_s1_ff;
      i1_s1_ff <= ext_irq_one_n;
      i1_s2_ff <= i1_s1_ff;
    end
  end

  // axi write: address and data taken in either order, one at a time
  assign wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wsel = reg_sel(aw_addr_ff);
  assign power_control_reg_wr = wr_go && wsel == REG_POWER_CONTROL_REG && w_strb_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= 8'h00;
      w_strb_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `CCPM_RESP_OKAY;
    end else begin
      if (awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        aw_have_ff <= 1'b1;
        aw_addr_ff <= awaddr;
      end
      if (wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        w_have_ff <= 1'b1;
        w_data_ff <= wdata[7:0];
        w_strb_ff <= wstrb[0];
      end
      if (wr_go) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (wsel == REG_NONE) ? `CCPM_RESP_SLVERR : `CCPM_RESP_OKAY;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // axi read: answer one cycle after the address is taken
  assign rsel = reg_sel(araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `CCPM_RESP_OKAY;
    end else if (arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= (rsel == REG_NONE) ? `CCPM_RESP_SLVERR : `CCPM_RESP_OKAY;
      unique case (rsel)
        REG_POWER_CONTROL_REG: rdata_ff <= {24'h000000, power_control_reg_misc_ff[7:2],
                               mode_ff == PM_PDOWN, mode_ff == PM_IDLE};
        REG_CLOCK_RATE_SELECT: rdata_ff <= {24'h000000, clock_rate_select_ff};
        REG_STAT: rdata_ff <= {26'h0000000, ram_block_ff, core_rst_ff,
                               x2_eff_ff, adc_idle_ff, mode_ff};
        REG_NONE: rdata_ff <= 32'h0000_0000;
      endcase
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // warm reset: pin held 24 periods, or internal source pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt_ff <= 5'h00;
      irst_cnt_ff <= 5'h00;
      core_rst_ff <= 1'b0;
    end else begin
      if (!rp_s2_ff) rst_cnt_ff <= 5'h00;
      else if (rst_cnt_ff != 5'(`CCPM_WARM_RST_CYC)) rst_cnt_ff <= rst_cnt_ff + 5'h01;
      if (int_warm_rst_req) irst_cnt_ff <= 5'(`CCPM_WARM_RST_CYC);
      else if (irst_cnt_ff != 5'h00) irst_cnt_ff <= irst_cnt_ff - 5'h01;
      core_rst_ff <= (rp_s2_ff && rst_cnt_ff == 5'(`CCPM_WARM_RST_CYC)) ||
                     irst_cnt_ff != 5'h00;
    end
  end

  // ram locked from reset-driven wake until internal reset takes over
  assign pin_wake = rp_s2_ff && mode_ff != PM_RUN;

  always_ff @(posedge aclk) begin
    if (!aresetn) ram_block_ff <= 1'b0;
    else if (pin_wake) ram_block_ff <= 1'b1;
    else if (core_rst_ff || !rp_s2_ff) ram_block_ff <= 1'b0;
  end

  // clock select register; warm reset reinitialises it
  always_ff @(posedge aclk) begin
    if (!aresetn || core_rst_ff) clock_rate_select_ff <= `CCPM_CLOCK_RATE_SELECT_RST;
    else if (wr_go && wsel == REG_CLOCK_RATE_SELECT && w_strb_ff) clock_rate_select_ff <= w_data_ff;
  end

  // plain power control bits; power-off flag survives warm reset
  always_ff @(posedge aclk) begin
    if (!aresetn) power_control_reg_misc_ff <= `CCPM_POWER_CONTROL_REG_RST;
    else if (core_rst_ff) power_control_reg_misc_ff <= power_control_reg_misc_ff & `CCPM_POWER_CONTROL_REG_RST;
    else if (power_control_reg_wr) begin
      power_control_reg_misc_ff <= w_data_ff;
      power_control_reg_misc_ff[`CCPM_POWER_CONTROL_REG_RSVD] <= 1'b0;
    end
  end

  // power mode sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= PM_RUN;
      adc_idle_ff <= 1'b0;
    end else if (rp_s2_ff || core_rst_ff) begin
      mode_ff <= PM_RUN;
      adc_idle_ff <= 1'b0;
    end else begin
      unique case (mode_ff)
        PM_RUN: begin
          if (power_control_reg_wr && w_data_ff[`CCPM_POWER_CONTROL_REG_PD]) mode_ff <= PM_PDOWN;
          else if (power_control_reg_wr && w_data_ff[`CCPM_POWER_CONTROL_REG_IDLE]) begin
            mode_ff <= PM_IDLE;
            adc_idle_ff <= adc_idle_mode;
          end
        end
        PM_IDLE: begin
          if (irq_pending || (adc_idle_ff && adc_conv_done)) begin
            mode_ff <= PM_RUN;
            adc_idle_ff <= 1'b0;
          end
        end
        PM_PDOWN: begin
          if (!i0_s2_ff || !i1_s2_ff) mode_ff <= PM_PDWAKE;
        end
        PM_PDWAKE: begin
          // cpu resumes only once the waking input is released
          if (i0_s2_ff && i1_s2_ff) mode_ff <= PM_RUN;
        end
      endcase
    end
  end

  // divide-by-two stage and speed select taken at its rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_ff <= 1'b0;
      x2_eff_ff <= 1'b0;
    end else if (mode_ff != PM_PDOWN) begin
      half_ff <= !half_ff;
      if (!half_ff) x2_eff_ff <= clock_rate_select_ff[`CCPM_CK_X2];
    end
  end

  // oscillator period count within a standard machine cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_ff <= 4'h0;
    else if (mode_ff != PM_PDOWN) begin
      if (cnt_ff == 4'(`CCPM_STD_PERIODS - 1)) cnt_ff <= 4'h0;
      else cnt_ff <= cnt_ff + 4'h1;
    end
  end

  // cycle enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_en_ff <= 1'b0;
      periph_en_ff <= '0;
    end else begin
      cpu_en_ff <= mode_ff == PM_RUN && ccpm_tick(cnt_ff, x2_eff_ff);
      for (int i = 0; i < 7; i++) begin
        periph_en_ff[i] <= mode_ff != PM_PDOWN &&
                           ccpm_tick(cnt_ff, x2_eff_ff && !clock_rate_select_ff[i+1]);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_en_ff <= 1'b1;
      halted_ff <= 1'b0;
    end else begin
      osc_en_ff <= mode_ff != PM_PDOWN;
      halted_ff <= mode_ff != PM_RUN;
    end
  end

  a_cpu_std_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_ff == 4'(`CCPM_STD_PERIODS - 1) && mode_ff == PM_RUN |=> cpu_en_ff)
    else $error("cpu cycle missing at frame end");

  a_cpu_std_mid: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_ff == 4'(`CCPM_X2_PERIODS - 1) && !x2_eff_ff |=> !cpu_en_ff)
    else $error("cpu ran fast at standard speed");

  a_periph_std_only: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_ff == 4'(`CCPM_X2_PERIODS - 1) && !x2_eff_ff |=> periph_en_ff == '0)
    else $error("peripheral ran fast with speed bit clear");

  a_periph_half_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_ff == 4'(`CCPM_X2_PERIODS - 1) && x2_eff_ff && mode_ff != PM_PDOWN
    |=> periph_en_ff == ~$past(clock_rate_select_ff[7:1]))
    else $error("peripheral rate does not follow its select bit");

  a_x2_half_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    x2_eff_ff != $past(x2_eff_ff) |-> half_ff && !$past(half_ff))
    else $error("speed changed off the half clock rise");

  a_idle_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    power_control_reg_wr && w_data_ff[1:0] == 2'h1 && mode_ff == PM_RUN && !rp_s2_ff && !core_rst_ff
    |=> mode_ff == PM_IDLE ##1 halted_ff && !cpu_en_ff)
    else $error("idle request not honoured");

  a_pd_over_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    power_control_reg_wr && w_data_ff[1:0] == 2'h3 && mode_ff == PM_RUN && !rp_s2_ff && !core_rst_ff
    |=> mode_ff == PM_PDOWN ##1 !osc_en_ff)
    else $error("both bits did not give power-down");

  a_idle_irq_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_ff == PM_IDLE && irq_pending |=> mode_ff == PM_RUN ##1 !halted_ff)
    else $error("interrupt did not end idle");

  a_adc_idle_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_ff == PM_IDLE && adc_idle_ff && adc_conv_done |=> mode_ff == PM_RUN)
    else $error("conversion done did not end idle");

  a_pin_ends_lowpower: assert property (@(posedge aclk) disable iff (!aresetn)
    rp_s2_ff && mode_ff != PM_RUN |=> mode_ff == PM_RUN && ram_block_ff ##1 osc_en_ff)
    else $error("reset pin did not end low power");

  a_idle_periph_run: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_ff == PM_IDLE && cnt_ff == 4'(`CCPM_STD_PERIODS - 1)
    |=> periph_en_ff == '1 && !cpu_en_ff)
    else $error("idle clocks wrong");

  a_pd_wake_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_ff == PM_PDOWN && !i0_s2_ff && !rp_s2_ff && !core_rst_ff
    |=> mode_ff == PM_PDWAKE ##1 osc_en_ff && halted_ff)
    else $error("external interrupt wake wrong");

  a_pd_keeps_sfr: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_ff == PM_PDOWN && !core_rst_ff && !wr_go |=> $stable(clock_rate_select_ff))
    else $error("power-down lost clock select");

  a_int_rst_len: assert property (@(posedge aclk) disable iff (!aresetn)
    int_warm_rst_req |=> ##1 core_rst_ff [*8])
    else $error("internal warm reset too short");

endmodule

// [ccpm_pin_model.sv]
// Purpose: far-side model of the reset pin and the two external interrupt pins
// Assumes: pins change by non-blocking assignment right after a rising aclk edge
// Notes: reset pin idles low (pull-down), interrupt pins idle high (pull-up)
`timescale 1ns/1ps

module ccpm_pin_model (
  // clock
  input wire logic aclk,
  // device pins
  output logic reset_pin,
  output logic ext_irq_zero_n,
  output logic ext_irq_one_n
);
  initial begin
    reset_pin = 1'b0;
    ext_irq_zero_n = 1'b1;
    ext_irq_one_n = 1'b1;
  end

  // warm reset: pin held high for n periods, 24 or more expected
  task automatic warm_reset(input int n);
    @(posedge aclk);
    reset_pin <= 1'b1;
    repeat (n) @(posedge aclk);
    reset_pin <= 1'b0;
  endtask

  // level wake on one line, held long enough for the oscillator to settle
  task automatic wake(input int j, input int n);
    @(posedge aclk);
    if (j == 0) ext_irq_zero_n <= 1'b0;
    else ext_irq_one_n <= 1'b0;
    repeat (n) @(posedge aclk);
    ext_irq_zero_n <= 1'b1;
    ext_irq_one_n <= 1'b1;
  endtask
endmodule

// [tb_clock_speed_power_mode_control.sv]
// Purpose: self-checking bench for the clock speed and power mode controller
// Assumes: register byte address is the word index times four
// Notes: read and write answers are checked from queues by a monitor process
`timescale 1ns/1ps
`include "ccpm_params.svh"

module tb_clock_speed_power_mode_control import ccpm_pkg::*; ();
  localparam logic [11:0] A_PC = 12'(`CCPM_IDX_POWER_CONTROL_REG * 4);
  localparam logic [11:0] A_CK = 12'(`CCPM_IDX_CLOCK_RATE_SELECT * 4);
  localparam logic [1:0] OK = `CCPM_RESP_OKAY;
  localparam logic [1:0] SE = `CCPM_RESP_SLVERR;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic reset_pin, irq0_n, irq1_n, irq_pending, adc_idle_mode, adc_conv_done, int_warm_rst_req;
  logic cpu_cycle_en, osc_enable, core_reset, ram_access_block, cpu_clock_halted;
  ccpm_periph_s pen;
  logic [7:0] en8;
  int err_count, compares, cyc;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  assign en8 = {cpu_cycle_en, pen};

  ccpm_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .reset_pin(reset_pin), .ext_irq_zero_n(irq0_n),
    .ext_irq_one_n(irq1_n), .irq_pending(irq_pending), .adc_idle_mode(adc_idle_mode),
    .adc_conv_done(adc_conv_done), .int_warm_rst_req(int_warm_rst_req), .cpu_cycle_en(cpu_cycle_en),
    .periph_cycle_en(pen), .osc_enable(osc_enable), .core_reset(core_reset),
    .ram_access_block(ram_access_block), .cpu_clock_halted(cpu_clock_halted));
  ccpm_pin_model pm (.aclk(aclk), .reset_pin(reset_pin), .ext_irq_zero_n(irq0_n), .ext_irq_one_n(irq1_n));

  task automatic end_sim();
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    bq.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] er, input logic [31:0] ed);
    rq.push_back({er, ed});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // answers are matched against the oldest expectation
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      compares++;
      if ({rresp, rdata} !== rq.pop_front()) begin
        err_count++;
        $display("MISMATCH %0t read answer", $time);
      end
    end
    if (bvalid && bready) begin
      compares++;
      if (bresp !== bq.pop_front()) begin
        err_count++;
        $display("MISMATCH %0t write answer", $time);
      end
    end
  end

  function automatic logic ob(input int c);
    case (c)
      0: ob = cpu_clock_halted;
      1: ob = osc_enable;
      2: ob = core_reset;
      default: ob = ram_access_block;
    endcase
  endfunction

  // poll for a level within n edges
  task automatic await(input int c, input logic v, input int n, input string m);
    int k;
    k = 0;
    while (ob(c) !== v && k < n) begin
      @(posedge aclk);
      k++;
    end
    chk(ob(c) === v, m);
  endtask

  // second full period of a cycle enable, after any speed switch settles
  task automatic per(input int i, input int e);
    int n;
    repeat (2) begin
      do @(posedge aclk); while (en8[i] !== 1'b1);
    end
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (en8[i] !== 1'b1);
    chk(n == e, "cycle period");
  endtask

  task automatic pulses(input int i, input int n, input int e);
    int p;
    p = 0;
    repeat (n) begin
      @(posedge aclk);
      if (en8[i] === 1'b1) p++;
    end
    chk(p == e, "pulse count");
  endtask

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("MISMATCH %0t timeout", $time);
      end_sim();
    end
  end

  initial begin
    logic [7:0] v;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {irq_pending, adc_idle_mode, adc_conv_done, int_warm_rst_req} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    err_count = 0;
    compares = 0;
    cyc = 0;
    void'($urandom(32'h1A02));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_CK, OK, 32'h0);
    rd(A_PC, OK, 32'h10);
    rd(12'h300, SE, 32'h0);
    wr(12'h300, 8'hFF, SE);
    rd(12'(`CCPM_IDX_STAT * 4), OK, 32'h0);
    wstrb <= 4'hE;
    wr(A_CK, 8'hFF, OK);
    wstrb <= 4'hF;
    rd(A_CK, OK, 32'h0);
    for (int t = 0; t < 4; t++) begin
      v = 8'($urandom);
      v[0] = t[0];
      wr(A_CK, v, OK);
      rd(A_CK, OK, {24'h0, v});
      per(7, v[0] ? 6 : 12);
      for (int k = 1; k < 8; k++) per(k - 1, (v[0] && !v[k]) ? 6 : 12);
    end
    wr(A_CK, 8'h00, OK);
    // the entry write is followed by register reads only until irq_pending is driven to end idle
    wr(A_PC, 8'h11, OK);
    await(0, 1'b1, 4, "idle entry");
    pulses(7, 24, 0);
    pulses(0, 24, 2);
    rd(A_PC, OK, 32'h11);
    irq_pending <= 1'b1;
    await(0, 1'b0, 4, "idle exit");
    irq_pending <= 1'b0;
    rd(A_PC, OK, 32'h10);
    adc_idle_mode <= 1'b1;
    wr(A_PC, 8'h11, OK);
    await(0, 1'b1, 4, "converter idle entry");
    adc_idle_mode <= 1'b0;
    adc_conv_done <= 1'b1;
    @(posedge aclk);
    adc_conv_done <= 1'b0;
    await(0, 1'b0, 4, "converter idle exit");
    for (int j = 0; j < 2; j++) begin
      wr(A_CK, 8'hA5, OK);
      wr(A_PC, 8'h13, OK);
      await(1, 1'b0, 4, "oscillator stop");
      pulses(0, 24, 0);
      rd(A_PC, OK, 32'h12);
      fork
        pm.wake(j, 40);
        begin
          await(1, 1'b1, 8, "oscillator restart");
          chk(cpu_clock_halted === 1'b1, "cpu held while line low");
        end
      join
      await(0, 1'b0, 8, "resume on release");
      rd(A_PC, OK, 32'h10);
      rd(A_CK, OK, 32'hA5);
    end
    wr(A_PC, 8'h11, OK);
    await(0, 1'b1, 4, "idle again");
    fork
      pm.warm_reset(30);
      begin
        await(0, 1'b0, 8, "reset pin ends idle");
        await(3, 1'b1, 4, "ram blocked");
        await(2, 1'b1, 30, "core reset");
      end
    join
    await(2, 1'b0, 8, "core reset release");
    rd(A_CK, OK, 32'h0);
    wr(A_PC, 8'h13, OK);
    await(1, 1'b0, 4, "power-down again");
    fork
      pm.warm_reset(30);
      await(1, 1'b1, 8, "reset pin restarts oscillator");
    join
    await(2, 1'b0, 8, "core reset release");
    rd(A_PC, OK, 32'h10);
    wr(A_CK, 8'h01, OK);
    int_warm_rst_req <= 1'b1;
    @(posedge aclk);
    int_warm_rst_req <= 1'b0;
    await(2, 1'b1, 3, "internal reset");
    await(2, 1'b0, 30, "internal reset release");
    rd(A_CK, OK, 32'h0);
    end_sim();
  end
endmodule
